// ===== src/pwp_pll_ctrl.sv
// PLL control, filter and clock selection, and precompensated MFM write path
`timescale 1ns/100ps
`include "pwp_map.svh"
module pwp_pll_ctrl #(
  parameter int BUF_DEPTH = 2,
  parameter int RELOCK_CYCLES = `PWP_NS_TO_MIN_CYC(`PWP_RELOCK_NS)
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [7:0] reg_rdata,
  input wire logic drive_kind_pin,
  input wire logic pump_or_precomp_select_pin_i,
  output logic pump_or_precomp_select_pin_o,
  output logic pump_or_precomp_select_pin_oe,
  input wire logic charge_pump_active,
  input wire logic id_search_active,
  input wire logic sep_locking,
  input wire logic preamble_pattern,
  input wire logic preamble_locked,
  input wire logic ext_read_gate,
  output logic lock_to_data,
  output logic [4:0] vco_divide_n,
  output logic vco_center_4p8,
  output logic [2:0] prescale_div,
  output logic low_rate_filter_switch,
  output logic mid_rate_filter_switch,
  input wire logic write_gate,
  input wire logic wr_bit_valid,
  output logic wr_bit_ready,
  input wire logic wr_bit,
  output logic write_data_out
);
  localparam int RW = (RELOCK_CYCLES > 1) ? $clog2(RELOCK_CYCLES + 1) : 1;

  logic [7:0] mode_reg;
  pwp_pkg::pwp_rate_e rate_reg;
  logic underrun_reg;
  logic scale_sel_reg;
  logic pump_reg;
  pwp_pkg::pwp_seq_e seq_reg;
  pwp_pkg::pwp_seq_e seq_next;
  logic [RW-1:0] relock_cnt_reg;
  pwp_pkg::pwp_rate_e eff_rate;
  logic pump_mon_en;
  logic xrg_en;
  logic [5:0] half_cnt_reg;
  logic [5:0] half_cycles;
  logic phase_reg;
  logic [2:0] hist_reg;
  logic boundary;
  logic bit_start;
  logic new_bit;
  logic pulse;
  pwp_pkg::pwp_tap_e tap;
  logic [2:0] pc_cycles;
  logic write_bit_taken;

  pwp_stream_if #(.W(1)) strm ();

  function automatic pwp_pkg::pwp_rate_e eff_rate_of(input pwp_pkg::pwp_rate_e r,
                                                     input logic kind);
    if (r == pwp_pkg::PWP_RATE_300K && !kind) begin
      eff_rate_of = pwp_pkg::PWP_RATE_250K;
    end else begin
      eff_rate_of = r;
    end
  endfunction : eff_rate_of

  function automatic logic [5:0] half_cell_cycles(input pwp_pkg::pwp_rate_e r);
    case (r)
      pwp_pkg::PWP_RATE_1M: half_cell_cycles = 6'(`PWP_NS_TO_MAX_CYC(`PWP_HALF_NS_1M));
      pwp_pkg::PWP_RATE_500K: half_cell_cycles = 6'(`PWP_NS_TO_MAX_CYC(`PWP_HALF_NS_500K));
      pwp_pkg::PWP_RATE_300K: half_cell_cycles = 6'(`PWP_NS_TO_MAX_CYC(`PWP_HALF_NS_300K));
      default: half_cell_cycles = 6'(`PWP_NS_TO_MAX_CYC(`PWP_HALF_NS_250K));
    endcase
  endfunction : half_cell_cycles

  function automatic logic [2:0] precomp_cycles(input pwp_pkg::pwp_rate_e r,
                                                input logic scale);
    case (r)
      pwp_pkg::PWP_RATE_1M: precomp_cycles = 3'(`PWP_NS_TO_MIN_CYC(`PWP_PC_NS_83));
      pwp_pkg::PWP_RATE_300K: begin
        precomp_cycles = scale ? 3'(`PWP_NS_TO_MIN_CYC(`PWP_PC_NS_208)) :
          3'(`PWP_NS_TO_MIN_CYC(`PWP_PC_NS_125));
      end
      pwp_pkg::PWP_RATE_250K: begin
        precomp_cycles = scale ? 3'(`PWP_NS_TO_MIN_CYC(`PWP_PC_NS_250)) :
          3'(`PWP_NS_TO_MIN_CYC(`PWP_PC_NS_125));
      end
      default: precomp_cycles = 3'(`PWP_NS_TO_MIN_CYC(`PWP_PC_NS_125));
    endcase
  endfunction : precomp_cycles

  assign pump_mon_en = mode_reg[`PWP_MODE_PUMP_BIT];
  assign xrg_en = mode_reg[`PWP_MODE_XRG_BIT];
  assign eff_rate = eff_rate_of(rate_reg, drive_kind_pin);

  // Register writes
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mode_reg <= `PWP_MODE_RESET;
      rate_reg <= pwp_pkg::pwp_rate_e'(`PWP_RATE_RESET);
    end else if (reg_we) begin
      if (reg_addr == `PWP_REG_MODE) begin
        mode_reg <= reg_wdata;
      end
      if (reg_addr == `PWP_REG_RATE) begin
        rate_reg <= pwp_pkg::pwp_rate_e'(reg_wdata[1:0]);
      end
    end
  end

  // Underrun is sticky; a new underrun beats a write-one clear
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      underrun_reg <= 1'b0;
    end else if (bit_start && !strm.valid) begin
      underrun_reg <= 1'b1;
    end else if (reg_we && reg_addr == `PWP_REG_STATUS && reg_wdata[`PWP_ST_UNDERRUN_BIT]) begin
      underrun_reg <= 1'b0;
    end
  end

  // Register reads, data one cycle after the strobe
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_re) begin
      case (reg_addr)
        `PWP_REG_MODE: reg_rdata <= mode_reg;
        `PWP_REG_RATE: reg_rdata <= {6'h00, rate_reg};
        `PWP_REG_STATUS: begin
          reg_rdata <= {2'h0, underrun_reg, scale_sel_reg, eff_rate, pump_reg, lock_to_data};
        end
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // Shared pin: pump monitor out, or precomp scale select in
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      scale_sel_reg <= 1'b0;
      pump_reg <= 1'b0;
    end else begin
      pump_reg <= charge_pump_active;
      if (!pump_mon_en) begin
        scale_sel_reg <= pump_or_precomp_select_pin_i;
      end
    end
  end

  assign pump_or_precomp_select_pin_oe = pump_mon_en;
  assign pump_or_precomp_select_pin_o = pump_mon_en & pump_reg;

  // ID search sequencer
  always_comb begin
    seq_next = seq_reg;
    case (seq_reg)
      pwp_pkg::PWP_SEQ_REF: begin
        if (id_search_active && !xrg_en && relock_cnt_reg == '0) begin
          seq_next = pwp_pkg::PWP_SEQ_HUNT;
        end
      end
      pwp_pkg::PWP_SEQ_HUNT: begin
        if (!id_search_active || xrg_en) begin
          seq_next = pwp_pkg::PWP_SEQ_REF;
        end else if (sep_locking && !preamble_pattern) begin
          seq_next = pwp_pkg::PWP_SEQ_REF;
        end else if (preamble_locked) begin
          seq_next = pwp_pkg::PWP_SEQ_TRACK;
        end
      end
      pwp_pkg::PWP_SEQ_TRACK: begin
        if (!id_search_active || xrg_en) begin
          seq_next = pwp_pkg::PWP_SEQ_REF;
        end
      end
      default: seq_next = pwp_pkg::PWP_SEQ_REF;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      seq_reg <= pwp_pkg::PWP_SEQ_REF;
    end else begin
      seq_reg <= seq_next;
    end
  end

  // Hold the reference lock for a while after a false lock
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      relock_cnt_reg <= '0;
    end else if (seq_reg == pwp_pkg::PWP_SEQ_HUNT && seq_next == pwp_pkg::PWP_SEQ_REF &&
                 id_search_active && !xrg_en) begin
      relock_cnt_reg <= RW'(RELOCK_CYCLES);
    end else if (relock_cnt_reg != '0) begin
      relock_cnt_reg <= RW'(relock_cnt_reg - 1'b1);
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      lock_to_data <= 1'b0;
    end else if (xrg_en) begin
      lock_to_data <= ext_read_gate;
    end else begin
      lock_to_data <= (seq_next != pwp_pkg::PWP_SEQ_REF);
    end
  end

  // Rate-dependent PLL, filter and clock settings
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      vco_divide_n <= `PWP_N_250K;
      vco_center_4p8 <= 1'b0;
      prescale_div <= `PWP_DIV_4M;
      low_rate_filter_switch <= 1'b1;
      mid_rate_filter_switch <= 1'b0;
    end else begin
      case (eff_rate)
        pwp_pkg::PWP_RATE_1M: begin
          vco_divide_n <= `PWP_N_1M;
          prescale_div <= `PWP_DIV_8M;
        end
        pwp_pkg::PWP_RATE_500K: begin
          vco_divide_n <= `PWP_N_500K;
          prescale_div <= `PWP_DIV_4M;
        end
        pwp_pkg::PWP_RATE_300K: begin
          vco_divide_n <= `PWP_N_300K;
          prescale_div <= `PWP_DIV_4M8;
        end
        default: begin
          vco_divide_n <= `PWP_N_250K;
          prescale_div <= `PWP_DIV_4M;
        end
      endcase
      vco_center_4p8 <= (eff_rate == pwp_pkg::PWP_RATE_300K);
      mid_rate_filter_switch <= (eff_rate == pwp_pkg::PWP_RATE_500K);
      low_rate_filter_switch <= (eff_rate == pwp_pkg::PWP_RATE_250K) ||
        (eff_rate == pwp_pkg::PWP_RATE_300K);
    end
  end

  // Write path: buffer, half-cell timing, MFM pulses, precomp
  pwp_fifo2 #(.W(1), .DEPTH(BUF_DEPTH)) u_buf (
    .clk(clk),
    .arst_n(arst_n),
    .in_valid(wr_bit_valid),
    .in_ready(wr_bit_ready),
    .in_data(wr_bit),
    .out(strm)
  );

  assign half_cycles = half_cell_cycles(eff_rate);
  assign boundary = write_gate && (half_cnt_reg == 6'(half_cycles - 1'b1));
  assign bit_start = boundary && phase_reg;
  assign write_bit_taken = bit_start && strm.valid;
  assign strm.ready = bit_start;
  assign new_bit = strm.valid & strm.data[0];

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      half_cnt_reg <= 6'h00;
      phase_reg <= 1'b1;
      hist_reg <= 3'h0;
    end else if (!write_gate) begin
      half_cnt_reg <= 6'h00;
      phase_reg <= 1'b1;
      hist_reg <= 3'h0;
    end else if (boundary) begin
      half_cnt_reg <= 6'h00;
      phase_reg <= ~phase_reg;
      if (bit_start) begin
        hist_reg <= {write_bit_taken & new_bit, hist_reg[2:1]};
      end
    end else begin
      half_cnt_reg <= 6'(half_cnt_reg + 1'b1);
    end
  end

  // hist_reg: [2] next bit, [1] current bit, [0] previous bit
  always_comb begin
    pulse = 1'b0;
    tap = pwp_pkg::PWP_TAP_NOMINAL;
    if (bit_start) begin
      pulse = ~hist_reg[1] & ~hist_reg[2];
    end else if (boundary) begin
      pulse = hist_reg[1];
      if (hist_reg[0] && !hist_reg[2]) begin
        tap = pwp_pkg::PWP_TAP_EARLY;
      end else if (!hist_reg[0] && hist_reg[2]) begin
        tap = pwp_pkg::PWP_TAP_LATE;
      end
    end
  end

  assign pc_cycles = precomp_cycles(eff_rate, scale_sel_reg);

  pwp_precomp_shift #(.CW(3)) u_pc (
    .clk(clk),
    .arst_n(arst_n),
    .tick_cycles(pc_cycles),
    .pulse_in(pulse),
    .tap_sel(tap),
    .wdata_out(write_data_out)
  );
endmodule : pwp_pll_ctrl

// ===== src/pwp_map.svh
// Register offsets, field positions, reset values and timing counts of the PLL/precomp block
`ifndef PWP_MAP_SVH
`define PWP_MAP_SVH

`define PWP_CLK_PERIOD_NS 100
`define PWP_NS_TO_MIN_CYC(ns) ((((ns) + `PWP_CLK_PERIOD_NS - 1) / `PWP_CLK_PERIOD_NS) < 1 ? \
  1 : (((ns) + `PWP_CLK_PERIOD_NS - 1) / `PWP_CLK_PERIOD_NS))
`define PWP_NS_TO_MAX_CYC(ns) (((ns) / `PWP_CLK_PERIOD_NS) < 1 ? 1 : ((ns) / `PWP_CLK_PERIOD_NS))

`define PWP_REG_MODE 4'h0
`define PWP_REG_RATE 4'h1
`define PWP_REG_STATUS 4'h2
`define PWP_MODE_PUMP_BIT 0
`define PWP_MODE_XRG_BIT 1
`define PWP_MODE_RESET 8'h00
`define PWP_RATE_RESET 2'h2
`define PWP_ST_LOCK_BIT 0
`define PWP_ST_PUMP_BIT 1
`define PWP_ST_RATE_LSB 2
`define PWP_ST_SCALE_BIT 4
`define PWP_ST_UNDERRUN_BIT 5

`define PWP_N_1M 5'h04
`define PWP_N_500K 5'h08
`define PWP_N_300K 5'h10
`define PWP_N_250K 5'h10
`define PWP_DIV_4M 3'h6
`define PWP_DIV_4M8 3'h5
`define PWP_DIV_8M 3'h3

`define PWP_HALF_NS_1M 500
`define PWP_HALF_NS_500K 1000
`define PWP_HALF_NS_300K 1667
`define PWP_HALF_NS_250K 2000
`define PWP_PC_NS_83 83
`define PWP_PC_NS_125 125
`define PWP_PC_NS_208 208
`define PWP_PC_NS_250 250
`define PWP_RELOCK_NS 1000

`endif

// ===== src/pwp_pkg.sv
// Types shared by the PLL/precomp block
package pwp_pkg;
  typedef enum logic [1:0] {
    PWP_RATE_500K = 2'h0,
    PWP_RATE_300K = 2'h1,
    PWP_RATE_250K = 2'h2,
    PWP_RATE_1M = 2'h3
  } pwp_rate_e;
  typedef enum logic [2:0] {
    PWP_SEQ_REF = 3'h1,
    PWP_SEQ_HUNT = 3'h2,
    PWP_SEQ_TRACK = 3'h4
  } pwp_seq_e;
  typedef enum logic [1:0] {
    PWP_TAP_EARLY = 2'h0,
    PWP_TAP_NOMINAL = 2'h1,
    PWP_TAP_LATE = 2'h2
  } pwp_tap_e;
endpackage : pwp_pkg

// ===== src/pwp_stream_if.sv
// Valid/ready stream between the write buffer and the write engine
`timescale 1ns/100ps
interface pwp_stream_if #(parameter int W = 1);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src(output valid, output data, input ready);
  modport snk(input valid, input data, output ready);
endinterface : pwp_stream_if

// ===== src/pwp_fifo2.sv
// Two-entry valid/ready buffer for write bits
`timescale 1ns/100ps
module pwp_fifo2 #(
  parameter int W = 1,
  parameter int DEPTH = 2
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  pwp_stream_if.src out
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wptr_reg;
  logic [AW-1:0] rptr_reg;
  logic [AW:0] count_reg;
  logic push;
  logic pop;

  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
    ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
  endfunction : ptr_inc

  assign in_ready = (count_reg != (AW + 1)'(DEPTH));
  assign out.valid = (count_reg != '0);
  assign out.data = mem[rptr_reg];
  assign push = in_valid & in_ready;
  assign pop = out.valid & out.ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wptr_reg] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wptr_reg <= ptr_inc(wptr_reg);
      end
      if (pop) begin
        rptr_reg <= ptr_inc(rptr_reg);
      end
      count_reg <= (AW + 1)'(count_reg + push - pop);
    end
  end
endmodule : pwp_fifo2

// ===== src/pwp_precomp_shift.sv
// Three-stage tapped shift register that places each write pulse early, nominal or late
`timescale 1ns/100ps
module pwp_precomp_shift #(
  parameter int CW = 3
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [CW-1:0] tick_cycles,
  input wire logic pulse_in,
  input wire pwp_pkg::pwp_tap_e tap_sel,
  output logic wdata_out
);
  logic [CW-1:0] tick_cnt_reg;
  logic tick;
  logic pending_reg;
  logic [2:0] stage_reg;
  logic [1:0] sel_reg;

  // One stage step equals the selected precomp amount
  assign tick = (tick_cnt_reg >= CW'(tick_cycles - 1'b1));

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tick_cnt_reg <= '0;
    end else if (tick) begin
      tick_cnt_reg <= '0;
    end else begin
      tick_cnt_reg <= CW'(tick_cnt_reg + 1'b1);
    end
  end

  // A pulse arriving on a step edge is inserted at once, never dropped
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pending_reg <= 1'b0;
      sel_reg <= 2'h1;
    end else begin
      pending_reg <= tick ? 1'b0 : (pending_reg | pulse_in);
      if (pulse_in) begin
        sel_reg <= tap_sel;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stage_reg <= 3'h0;
    end else if (tick) begin
      stage_reg <= {stage_reg[1:0], pending_reg | pulse_in};
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wdata_out <= 1'b0;
    end else begin
      wdata_out <= stage_reg[sel_reg];
    end
  end
endmodule : pwp_precomp_shift

// ===== bench/pwp_pll_ctrl_chk.sv
// Port assertions for the PLL control and precomp block
`timescale 1ns/100ps
`include "pwp_map.svh"
module pwp_pll_ctrl_chk #(
  parameter int BUF_DEPTH = 2,
  parameter int RELOCK_CYCLES = 10
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_we,
  input wire logic drive_kind_pin,
  input wire logic pump_or_precomp_select_pin_o,
  input wire logic pump_or_precomp_select_pin_oe,
  input wire logic charge_pump_active,
  input wire logic id_search_active,
  input wire logic ext_read_gate,
  input wire logic lock_to_data,
  input wire logic [4:0] vco_divide_n,
  input wire logic vco_center_4p8,
  input wire logic [2:0] prescale_div,
  input wire logic low_rate_filter_switch,
  input wire logic mid_rate_filter_switch
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  logic pump_q;
  logic xrg_q;
  // Shadow of the mode bits
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pump_q <= 1'b0;
      xrg_q <= 1'b0;
    end else if (reg_we && reg_addr == `PWP_REG_MODE) begin
      pump_q <= reg_wdata[`PWP_MODE_PUMP_BIT];
      xrg_q <= reg_wdata[`PWP_MODE_XRG_BIT];
    end
  end
  property p_pump_oe;
    pump_or_precomp_select_pin_oe == pump_q;
  endproperty
  a_pump_oe: assert property (p_pump_oe) else $error("pin enable differs from mode");
  property p_pump_out;
    pump_or_precomp_select_pin_o == (pump_or_precomp_select_pin_oe && $past(charge_pump_active));
  endproperty
  a_pump_out: assert property (p_pump_out) else $error("pump pin wrong");
  property p_xrg;
    xrg_q && $past(xrg_q) |-> lock_to_data == $past(ext_read_gate);
  endproperty
  a_xrg: assert property (p_xrg) else $error("lock ignores read gate");
  property p_idle;
    (!xrg_q && !id_search_active) [*2] |=> !lock_to_data;
  endproperty
  a_idle: assert property (p_idle) else $error("lock without search");
  property p_mid;
    mid_rate_filter_switch |-> vco_divide_n == 5'h08 && prescale_div == 3'h6;
  endproperty
  a_mid: assert property (p_mid) else $error("mid rate settings wrong");
  property p_fast;
    prescale_div == 3'h3 |-> vco_divide_n == 5'h04 && !low_rate_filter_switch
      && !mid_rate_filter_switch;
  endproperty
  a_fast: assert property (p_fast) else $error("fast rate settings wrong");
  property p_ctr;
    vco_center_4p8 |-> prescale_div == 3'h5 && vco_divide_n == 5'h10 && low_rate_filter_switch;
  endproperty
  a_ctr: assert property (p_ctr) else $error("high centre settings wrong");
  property p_kind;
    !drive_kind_pin [*3] |-> !vco_center_4p8;
  endproperty
  a_kind: assert property (p_kind) else $error("high centre with kind low");
  property p_div;
    prescale_div inside {3'h3, 3'h5, 3'h6} && low_rate_filter_switch ==
      (prescale_div != 3'h3 && !mid_rate_filter_switch);
  endproperty
  a_div: assert property (p_div) else $error("prescaler code wrong");
endmodule : pwp_pll_ctrl_chk
bind pwp_pll_ctrl pwp_pll_ctrl_chk #(.BUF_DEPTH(BUF_DEPTH), .RELOCK_CYCLES(RELOCK_CYCLES))
  chk_u (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_we(reg_we), .drive_kind_pin(drive_kind_pin),
  .pump_or_precomp_select_pin_o(pump_or_precomp_select_pin_o),
  .pump_or_precomp_select_pin_oe(pump_or_precomp_select_pin_oe),
  .charge_pump_active(charge_pump_active), .id_search_active(id_search_active),
  .ext_read_gate(ext_read_gate), .lock_to_data(lock_to_data), .vco_divide_n(vco_divide_n),
  .vco_center_4p8(vco_center_4p8), .prescale_div(prescale_div),
  .low_rate_filter_switch(low_rate_filter_switch),
  .mid_rate_filter_switch(mid_rate_filter_switch));

// ===== bench/pwp_drive_model.sv
// Drive side: records write pulse edges and picks the external filter
`timescale 1ns/100ps
module pwp_drive_model (
  input wire logic clk,
  input wire logic write_data_in,
  input wire logic low_sw,
  input wire logic mid_sw,
  input wire logic fm_mode,
  output logic [1:0] ext_filter
);
  int cyc = 0;
  int rise_q[$];
  int fall_q[$];
  logic prev = 1'b0;
  // FM filters need their own switching outside the controller
  assign ext_filter = fm_mode ? 2'h0 : {low_sw, mid_sw};
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (write_data_in && !prev) rise_q.push_back(cyc);
    if (!write_data_in && prev) fall_q.push_back(cyc);
    prev <= write_data_in;
  end
endmodule : pwp_drive_model

// ===== bench/pwp_pll_ctrl_tb.sv
// Self-checking bench for the PLL control and precomp block
`timescale 1ns/100ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin bad_count++; \
  $display("mismatch %s exp %0h got %0h", nm, e, g); end end
module pwp_pll_ctrl_tb;
  localparam int RLK = 10;
  logic clk = 1'b0, arst_n = 1'b0, reg_we = 1'b0, reg_re = 1'b0, kind = 1'b1, strap = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00, reg_rdata;
  logic cpa = 1'b0, id_s = 1'b0, sep_l = 1'b0, pre_p = 1'b0, pre_l = 1'b0, xrg = 1'b0;
  logic wgate = 1'b0, wvalid = 1'b0, wbit = 1'b0, wready, wdo, lock, ctr, low, mid;
  logic pin_o, pin_oe, pin_i;
  logic [4:0] vco_n;
  logic [2:0] pdiv;
  int bad_count = 0;
  int num_checks = 0;
  assign pin_i = pin_oe ? pin_o : strap;
  pwp_pll_ctrl #(.BUF_DEPTH(2), .RELOCK_CYCLES(RLK)) dut_u (.clk(clk), .arst_n(arst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
    .reg_rdata(reg_rdata), .drive_kind_pin(kind), .pump_or_precomp_select_pin_i(pin_i),
    .pump_or_precomp_select_pin_o(pin_o), .pump_or_precomp_select_pin_oe(pin_oe),
    .charge_pump_active(cpa), .id_search_active(id_s), .sep_locking(sep_l),
    .preamble_pattern(pre_p), .preamble_locked(pre_l), .ext_read_gate(xrg),
    .lock_to_data(lock), .vco_divide_n(vco_n), .vco_center_4p8(ctr), .prescale_div(pdiv),
    .low_rate_filter_switch(low), .mid_rate_filter_switch(mid), .write_gate(wgate),
    .wr_bit_valid(wvalid), .wr_bit_ready(wready), .wr_bit(wbit), .write_data_out(wdo));
  pwp_drive_model drv_u (.clk(clk), .write_data_in(wdo), .low_sw(low), .mid_sw(mid),
    .fm_mode(1'b0), .ext_filter());
  initial begin
    forever #50 clk = ~clk;
  end
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_we <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_we <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] e, input string nm);
    @(posedge clk);
    reg_re <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_re <= 1'b0;
    @(negedge clk);
    `CHK(nm, e, reg_rdata)
  endtask : rd
  task automatic wait_lock(input logic v, input int lim, output int n);
    n = 0;
    while (lock !== v && n < lim) begin
      @(posedge clk);
      n++;
    end
  endtask : wait_lock
  task automatic push(input logic v);
    int n;
    wvalid <= 1'b1;
    wbit <= v;
    n = 0;
    @(negedge clk);
    while (wready !== 1'b1 && n < 400) begin
      @(negedge clk);
      n++;
    end
    if (n >= 400) bad_count++;
    @(posedge clk);
  endtask : push
  task automatic t_rates;
    logic [4:0] en [5] = '{5'h08, 5'h10, 5'h10, 5'h04, 5'h10};
    logic [2:0] ed [5] = '{3'h6, 3'h5, 3'h6, 3'h3, 3'h6};
    logic [2:0] ef [5] = '{3'h1, 3'h6, 3'h2, 3'h0, 3'h2};
    `CHK("reset_div", 3'h6, pdiv)
    for (int i = 0; i < 5; i++) begin
      @(posedge clk);
      kind <= (i != 4);
      wr(4'h1, (i == 4) ? 8'h01 : 8'(i));
      repeat (3) @(posedge clk);
      @(negedge clk);
      `CHK("vco_n", en[i], vco_n)
      `CHK("pdiv", ed[i], pdiv)
      `CHK("ctr_low_mid", ef[i], {ctr, low, mid})
    end
    @(posedge clk);
    kind <= 1'b1;
    $display("test rates done");
  endtask : t_rates
  task automatic t_regs;
    wr(4'h0, 8'ha4);
    rd(4'h0, 8'ha4, "mode");
    rd(4'hf, 8'h00, "unmapped");
    wr(4'h0, 8'h01);
    @(posedge clk);
    cpa <= 1'b1;
    repeat (2) @(posedge clk);
    @(negedge clk);
    `CHK("pin_oe", 1'b1, pin_oe)
    `CHK("pin_on", 1'b1, pin_o)
    @(posedge clk);
    cpa <= 1'b0;
    repeat (2) @(posedge clk);
    @(negedge clk);
    `CHK("pin_off", 1'b0, pin_o)
    wr(4'h0, 8'h00);
    $display("test registers done");
  endtask : t_regs
  task automatic t_lock;
    int n;
    wr(4'h0, 8'h02);
    @(posedge clk);
    sep_l <= 1'b1;
    xrg <= 1'b1;
    wait_lock(1'b1, 3, n);
    `CHK("xrg_n", 2, n)
    xrg <= 1'b0;
    wait_lock(1'b0, 3, n);
    `CHK("xrg_off", 1'b0, lock)
    sep_l <= 1'b0;
    wr(4'h0, 8'h00);
    @(posedge clk);
    id_s <= 1'b1;
    wait_lock(1'b1, 20, n);
    `CHK("hunt", 1'b1, lock)
    sep_l <= 1'b1;
    pre_p <= 1'b1;
    repeat (4) @(posedge clk);
    `CHK("preamble_kept", 1'b1, lock)
    pre_p <= 1'b0;
    @(posedge clk);
    sep_l <= 1'b0;
    wait_lock(1'b0, 5, n);
    `CHK("relock", 1'b0, lock)
    wait_lock(1'b1, 40, n);
    `CHK("relock_hold", 1'b1, n >= RLK && n <= RLK + 4)
    pre_l <= 1'b1;
    @(posedge clk);
    pre_l <= 1'b0;
    sep_l <= 1'b1;
    repeat (4) @(posedge clk);
    `CHK("track", 1'b1, lock)
    sep_l <= 1'b0;
    id_s <= 1'b0;
    repeat (3) @(posedge clk);
    @(negedge clk);
    `CHK("search_off", 1'b0, lock)
    $display("test lock done");
  endtask : t_lock
  task automatic t_prec(input logic [7:0] rate, input logic sv, input int c, input int s);
    logic [7:0] b = 8'h30;
    int i;
    int t;
    wr(4'h1, rate);
    @(posedge clk);
    strap <= sv;
    drv_u.rise_q.delete();
    drv_u.fall_q.delete();
    for (i = 0; i < 8; i++) begin
      if (i == 2) wgate <= 1'b1;
      push(b[i]);
    end
    wvalid <= 1'b0;
    repeat (6 * c) @(posedge clk);
    wgate <= 1'b0;
    t = s - 1;
    i = 0;
    while (i + 4 < drv_u.fall_q.size() && drv_u.rise_q[i+1] - drv_u.rise_q[i] <= c + c / 2) i++;
    `CHK("gap_late", 1'b1, i + 4 < drv_u.fall_q.size())
    if (i + 4 < drv_u.fall_q.size()) begin
      `CHK("late", 0, (drv_u.rise_q[i+1] - drv_u.rise_q[i] - (c + c/2 + s)) / (t + 1))
      `CHK("pair", 0, (drv_u.rise_q[i+2] - drv_u.rise_q[i+1] - (c - 2*s)) / (t + 1))
      `CHK("early", 0, (drv_u.rise_q[i+3] - drv_u.rise_q[i+2] - (c + c/2 + s)) / (t + 1))
      `CHK("width", s, drv_u.fall_q[i+1] - drv_u.rise_q[i+1])
    end
    rd(4'h2, {2'h0, 1'b1, sv, rate[1:0], 2'h0}, "status");
    wr(4'h2, 8'h20);
    rd(4'h2, {3'h0, sv, rate[1:0], 2'h0}, "status_clr");
    $display("test precomp rate %0h select %0d done", rate, sv);
  endtask : t_prec
  task automatic results;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : results
  initial begin
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    @(negedge clk);
    t_rates();
    t_regs();
    t_lock();
    t_prec(8'h03, 1'b0, 10, 1);
    t_prec(8'h02, 1'b0, 40, 2);
    t_prec(8'h02, 1'b1, 40, 3);
    t_prec(8'h01, 1'b1, 32, 3);
    results();
  end
  initial begin
    #(100 * 20000);
    bad_count++;
    results();
  end
endmodule : pwp_pll_ctrl_tb
